// File: pkg/sll_pkg.sv
// Constants, types and register map of the serial link layer transmitter
// ==========================================================================
package sll_pkg;
    // ======================================================================
    // Register map
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_CFG = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_MODE64 = 1;
    localparam int CTRL_SCRAMBLE = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [7:0] F_M1_RST = 8'h01;
    localparam logic [7:0] K_M1_RST = 8'h1F;
    // ======================================================================
    // Framing limits
    localparam logic [16:0] FK_MIN = 17'h00011;
    localparam logic [16:0] FK_MAX = 17'h00400;
    localparam int LANE_ALIGNMENT_SEQUENCE_MFS = 4;
    localparam int MB_BLOCKS = 32;
    localparam int EMB_E = 1;
    localparam logic [31:0] HDR_STREAM = 32'h80E88888;
    // ======================================================================
    // Control characters (pre-encoding octet values), scrambler seeds and SYNC reset level
    localparam logic [7:0] K28_0 = 8'h1C;
    localparam logic [7:0] K28_3 = 8'h7C;
    localparam logic [7:0] K28_4 = 8'h9C;
    localparam logic [7:0] K28_5 = 8'hBC;
    localparam logic [7:0] K28_7 = 8'hFC;
    localparam logic [14:0] SCR8_SEED = 15'h7FFF;
    localparam logic [57:0] SCR64_SEED = 58'h3FFFFFFFFFFFFFF;
    localparam logic SYNC_RST = 1'b0;
    // ======================================================================
    // Link states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CGS = 2'b01,
        ST_LANE_ALIGNMENT_SEQUENCE = 2'b10,
        ST_DATA = 2'b11
    } sll_state_e;
endpackage

// File: pkg/sll_enc_if.sv
// Octet-to-encoder carrier between the link layer and the 8b/10b encoder
`timescale 1ns/10ps
interface sll_enc_if;
    logic valid;
    logic [7:0] octet;
    logic is_k;
    logic [9:0] code;
    modport enc(input valid, input octet, input is_k, output code);
    modport src(output valid, output octet, output is_k, input code);
endinterface

// File: verilog/sll_enc8b10b.sv
// 8b/10b character encoder with running disparity
`timescale 1ns/10ps
module sll_enc8b10b (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Octet in, character out
    sll_enc_if.enc enc
);
    // ======================================================================
    // Code tables, negative-disparity forms, first sent bit is MSB
    localparam logic [5:0] T6 [0:31] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0] T4D [0:7] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
    localparam logic [3:0] T4K [0:7] = '{4'hB, 4'h6, 4'hA, 4'hC, 4'hD, 4'h5, 4'h9, 4'h7};
    localparam logic [5:0] K28_6B = 6'h0F;
    localparam logic [3:0] ALT7 = 4'h7;

    logic rd;
    logic [9:0] code;
    wire [4:0] lo = enc.octet[4:0];
    wire [2:0] hi = enc.octet[7:5];
    wire [5:0] c6_m = enc.is_k ? K28_6B : T6[lo];
    wire flip6 = rd && (($countones(c6_m) != 3) || (!enc.is_k && lo == 5'h07));
    wire [5:0] c6 = flip6 ? ~c6_m : c6_m;
    wire rd6 = ($countones(c6) != 3) ? ~rd : rd;
    // Alternate 7 avoids a run of five equal bits across the sub-blocks
    wire alt7 = !enc.is_k && hi == 3'h7 &&
        ((!rd6 && (lo == 5'h11 || lo == 5'h12 || lo == 5'h14)) ||
         (rd6 && (lo == 5'h0B || lo == 5'h0D || lo == 5'h0E)));
    wire [3:0] c4_m = enc.is_k ? T4K[hi] : (alt7 ? ALT7 : T4D[hi]);
    wire flip4 = rd6 && (enc.is_k || ($countones(c4_m) != 2) || hi == 3'h3);
    wire [3:0] c4 = flip4 ? ~c4_m : c4_m;
    wire rd4 = ($countones(c4) != 2) ? ~rd6 : rd6;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rd <= 1'b0;
            code <= 10'h000;
        end else if (enc.valid) begin
            rd <= rd4;
            code <= {c6, c4};
        end
    end

    assign enc.code = code;
endmodule // sll_enc8b10b

// File: verilog/sll_link_tx.sv
// Transmit link layer: 8b/10b link start-up and 64b/66b block framing
`timescale 1ns/10ps
module sll_link_tx (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Link control pins
    input wire logic sync_n_in,
    input wire logic sysref_in,
    // Transport octet stream
    input wire logic [7:0] octet_in,
    input wire logic octet_valid_in,
    output logic octet_ready_out,
    // Encoded outputs
    output logic [9:0] char_out,
    output logic char_valid_out,
    output logic [0:65] block_out,
    output logic block_valid_out
);
    // ======================================================================
    // Functions
    function automatic logic [22:0] scr8(input logic [14:0] s, input logic [7:0] d);
        logic [14:0] st;
        logic [7:0] o;
        st = s;
        o = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            o[i] = d[i] ^ st[13] ^ st[14];
            st = {st[13:0], o[i]};
        end
        return {st, o};
    endfunction

    function automatic logic [121:0] scr64(input logic [57:0] s, input logic [0:63] d);
        logic [57:0] st;
        logic [0:63] o;
        st = s;
        o = 64'h0;
        for (int i = 0; i < 64; i++) begin
            o[i] = d[i] ^ st[38] ^ st[57];
            st = {st[56:0], o[i]};
        end
        return {st, o};
    endfunction

    // ======================================================================
    // Registers
    logic ctrl_en;
    logic ctrl_m64;
    logic ctrl_scr;
    logic [7:0] f_m1;
    logic [7:0] k_m1;
    logic [31:0] rdata;
    sll_pkg::sll_state_e state;
    sll_pkg::sll_state_e next_state;
    logic [1:0] lane_alignment_sequence_mf;
    logic [9:0] multiframe_boundary_counter_cnt;
    logic [7:0] fpos;
    logic [7:0] ext_cnt;
    logic [2:0] sync_sh;
    logic [2:0] sref_sh;
    logic sync_lvl;
    logic sref_lvl;
    logic [7:0] prev_last;
    logic [14:0] scr8_st;
    logic [57:0] scr64_st;
    logic [0:55] blk_buf;

    // ======================================================================
    // APB decode, zero wait states
    wire setup = psel_in && !penable_in;
    wire access = psel_in && penable_in;
    wire hit_ctrl = paddr_in == sll_pkg::REG_CTRL;
    wire hit_cfg = paddr_in == sll_pkg::REG_CFG;
    wire hit_stat = paddr_in == sll_pkg::REG_STATUS;
    wire hit = hit_ctrl || hit_cfg || hit_stat;
    wire wr = access && pwrite_in && hit;
    assign pready_out = 1'b1;
    assign pslverr_out = access && !hit;
    assign prdata_out = rdata;

    // K range check: F*K between 17 and 1024, K up to 256 by width
    wire [16:0] fk = 17'(({1'b0, f_m1} + 9'h001) * ({1'b0, k_m1} + 9'h001));
    wire param_err = (fk < sll_pkg::FK_MIN) || (fk > sll_pkg::FK_MAX);
    wire [9:0] fk_last = 10'(fk - 17'h00001);

    wire [31:0] stat_word = {6'h00, multiframe_boundary_counter_cnt, ext_cnt, 4'h0, param_err, sync_lvl, state};
    wire [31:0] rd_mux = hit_ctrl ? {29'h0, ctrl_scr, ctrl_m64, ctrl_en} :
                         hit_cfg ? {16'h0, k_m1, f_m1} :
                         hit_stat ? stat_word : 32'h0;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            {ctrl_scr, ctrl_m64, ctrl_en} <= sll_pkg::CTRL_RST;
            f_m1 <= sll_pkg::F_M1_RST;
            k_m1 <= sll_pkg::K_M1_RST;
            rdata <= 32'h0;
        end else begin
            if (setup) begin
                rdata <= rd_mux;
            end
            if (wr && hit_ctrl) begin
                ctrl_en <= pwdata_in[sll_pkg::CTRL_ENABLE];
                ctrl_m64 <= pwdata_in[sll_pkg::CTRL_MODE64];
                ctrl_scr <= pwdata_in[sll_pkg::CTRL_SCRAMBLE];
            end
            if (wr && hit_cfg) begin
                f_m1 <= pwdata_in[7:0];
                k_m1 <= pwdata_in[15:8];
            end
        end
    end

    // ======================================================================
    // Pin synchronisers, level accepted when stages two and three agree
    wire sync_agree = sync_sh[1] == sync_sh[2];
    wire sref_agree = sref_sh[1] == sref_sh[2];
    wire sref_edge = sref_agree && sref_sh[2] && !sref_lvl;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sync_sh <= 3'h0;
            sref_sh <= 3'h0;
            sync_lvl <= sll_pkg::SYNC_RST;
            sref_lvl <= 1'b0;
        end else begin
            sync_sh <= {sync_sh[1:0], sync_n_in};
            sref_sh <= {sref_sh[1:0], sysref_in};
            if (sync_agree) begin
                sync_lvl <= sync_sh[2];
            end
            if (sref_agree) begin
                sref_lvl <= sref_sh[2];
            end
        end
    end

    // ======================================================================
    // Multiframe and extended multiblock counters
    wire mf_last = multiframe_boundary_counter_cnt == fk_last;
    wire frame_last = fpos == f_m1;

    always_ff @(posedge clk_in) begin
        if (reset_in || sref_edge) begin
            multiframe_boundary_counter_cnt <= 10'h000;
            fpos <= 8'h00;
            ext_cnt <= 8'h00;
        end else begin
            multiframe_boundary_counter_cnt <= mf_last ? 10'h000 : multiframe_boundary_counter_cnt + 10'h001;
            fpos <= (frame_last || mf_last) ? 8'h00 : fpos + 8'h01;
            ext_cnt <= ext_cnt + 8'h01;
        end
    end

    // ======================================================================
    // Link start-up state machine
    wire m8 = ctrl_en && !ctrl_m64;
    wire m64 = ctrl_en && ctrl_m64;

    always_comb begin
        next_state = state;
        case (state)
            sll_pkg::ST_IDLE: begin
                next_state = sll_pkg::ST_CGS;
            end
            sll_pkg::ST_CGS: begin
                if (sync_lvl && mf_last) begin
                    next_state = sll_pkg::ST_LANE_ALIGNMENT_SEQUENCE;
                end
            end
            sll_pkg::ST_LANE_ALIGNMENT_SEQUENCE: begin
                if (mf_last && lane_alignment_sequence_mf == 2'(sll_pkg::LANE_ALIGNMENT_SEQUENCE_MFS - 1)) begin
                    next_state = sll_pkg::ST_DATA;
                end
            end
            sll_pkg::ST_DATA: begin
                next_state = sll_pkg::ST_DATA;
            end
            default: begin
                next_state = sll_pkg::ST_IDLE;
            end
        endcase
        if (!m8) begin
            next_state = sll_pkg::ST_IDLE;
        end else if (!sync_lvl) begin
            next_state = sll_pkg::ST_CGS;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state <= sll_pkg::ST_IDLE;
            lane_alignment_sequence_mf <= 2'h0;
        end else begin
            state <= next_state;
            lane_alignment_sequence_mf <= (state != sll_pkg::ST_LANE_ALIGNMENT_SEQUENCE) ? 2'h0 : lane_alignment_sequence_mf + 2'(mf_last);
        end
    end

    // ======================================================================
    // Alignment sequence content, never scrambled
    wire cfg_mf = lane_alignment_sequence_mf == 2'h1;
    wire lane_alignment_sequence_k = multiframe_boundary_counter_cnt == 10'h000 || mf_last || (cfg_mf && multiframe_boundary_counter_cnt == 10'h001);
    wire [7:0] lane_alignment_sequence_cfg = (multiframe_boundary_counter_cnt == 10'h002) ? f_m1 :
                          (multiframe_boundary_counter_cnt == 10'h003) ? k_m1 : {7'h00, ctrl_scr};
    wire [7:0] lane_alignment_sequence_oct = (multiframe_boundary_counter_cnt == 10'h000) ? sll_pkg::K28_0 :
                          mf_last ? sll_pkg::K28_3 :
                          (cfg_mf && multiframe_boundary_counter_cnt == 10'h001) ? sll_pkg::K28_4 :
                          (cfg_mf && multiframe_boundary_counter_cnt < 10'h005) ? lane_alignment_sequence_cfg :
                          multiframe_boundary_counter_cnt[7:0];

    // ======================================================================
    // User data, optional scrambling and alignment characters
    wire [7:0] din = octet_valid_in ? octet_in : 8'h00;
    wire [22:0] s8 = scr8(scr8_st, din);
    wire [7:0] dval = ctrl_scr ? s8[7:0] : din;
    wire rep = frame_last && dval == prev_last;
    wire a_sub = ctrl_scr ? (mf_last && dval == sll_pkg::K28_3) : (rep && mf_last);
    wire f_sub = ctrl_scr ? (frame_last && dval == sll_pkg::K28_7) : (rep && !mf_last);
    wire [7:0] data_oct = a_sub ? sll_pkg::K28_3 :
                          f_sub ? sll_pkg::K28_7 : dval;
    wire in_data = state == sll_pkg::ST_DATA;
    wire in_lane_alignment_sequence = state == sll_pkg::ST_LANE_ALIGNMENT_SEQUENCE;
    wire in_cgs = state == sll_pkg::ST_CGS;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            prev_last <= 8'h00;
            scr8_st <= sll_pkg::SCR8_SEED;
        end else begin
            if (in_data && frame_last) begin
                prev_last <= dval;
            end
            scr8_st <= (in_data && ctrl_scr) ? s8[22:8] : sll_pkg::SCR8_SEED;
        end
    end

    // ======================================================================
    // Character encoder
    sll_enc_if enc_if();
    assign enc_if.valid = m8 && state != sll_pkg::ST_IDLE;
    assign enc_if.is_k = in_cgs || (in_lane_alignment_sequence && lane_alignment_sequence_k) || (in_data && (a_sub || f_sub));
    assign enc_if.octet = in_cgs ? sll_pkg::K28_5 : in_lane_alignment_sequence ? lane_alignment_sequence_oct : data_oct;
    assign char_out = enc_if.code;
    assign octet_ready_out = in_data || m64;

    sll_enc8b10b u_enc (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .enc(enc_if)
    );

    // ======================================================================
    // 64b/66b block framing, scrambler always on in this mode
    wire [0:63] blk_raw = {blk_buf, din};
    wire [121:0] s64 = scr64(scr64_st, blk_raw);
    wire blk_end = ext_cnt[2:0] == 3'h7;
    wire hdr_bit = sll_pkg::HDR_STREAM[ext_cnt[7:3]];
    wire [0:1] hdr = hdr_bit ? 2'b01 : 2'b10;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            blk_buf <= 56'h0;
            scr64_st <= sll_pkg::SCR64_SEED;
            block_out <= 66'h0;
            block_valid_out <= 1'b0;
            char_valid_out <= 1'b0;
        end else begin
            char_valid_out <= enc_if.valid;
            block_valid_out <= m64 && blk_end;
            if (m64) begin
                blk_buf <= {blk_buf[8:55], din};
            end
            if (m64 && blk_end) begin
                scr64_st <= s64[121:64];
                block_out <= {hdr, s64[63:0]};
            end
        end
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    property p_comma;
        in_cgs |-> enc_if.is_k && enc_if.octet == sll_pkg::K28_5;
    endproperty
    a_comma: assert property (p_comma) else $error("comma missing while sync low");

    property p_lane_alignment_sequence_start;
        $rose(in_lane_alignment_sequence) |-> multiframe_boundary_counter_cnt == 10'h000 && $past(sync_lvl);
    endproperty
    a_lane_alignment_sequence_start: assert property (p_lane_alignment_sequence_start) else $error("sequence off boundary");

    property p_lane_alignment_sequence_bounds;
        in_lane_alignment_sequence && mf_last |-> enc_if.is_k && enc_if.octet == sll_pkg::K28_3;
    endproperty
    a_lane_alignment_sequence_bounds: assert property (p_lane_alignment_sequence_bounds) else $error("bad multiframe end");

    property p_lane_alignment_sequence_cfg;
        in_lane_alignment_sequence && cfg_mf && multiframe_boundary_counter_cnt == 10'h002 && !mf_last |-> enc_if.octet == f_m1;
    endproperty
    a_lane_alignment_sequence_cfg: assert property (p_lane_alignment_sequence_cfg) else $error("config octet wrong");

    property p_multiframe_boundary_counter_wrap;
        mf_last && !sref_edge |=> multiframe_boundary_counter_cnt == 10'h000;
    endproperty
    a_multiframe_boundary_counter_wrap: assert property (p_multiframe_boundary_counter_wrap) else $error("multiframe wrap wrong");

    property p_sysref;
        sref_edge |=> multiframe_boundary_counter_cnt == 10'h000 && ext_cnt == 8'h00;
    endproperty
    a_sysref: assert property (p_sysref) else $error("counters not reset");

    property p_sync_drop;
        m8 && state != sll_pkg::ST_IDLE && !sync_lvl |=> in_cgs || !m8;
    endproperty
    a_sync_drop: assert property (p_sync_drop) else $error("no restart on sync");

    property p_rep;
        in_data && !ctrl_scr && rep && !mf_last |-> enc_if.is_k && enc_if.octet == sll_pkg::K28_7;
    endproperty
    a_rep: assert property (p_rep) else $error("repeat not replaced");

    property p_char_bal;
        char_valid_out |-> $countones(char_out) >= 4 && $countones(char_out) <= 6;
    endproperty
    a_char_bal: assert property (p_char_bal) else $error("unbalanced character");

    property p_hdr;
        block_valid_out |-> block_out[0] != block_out[1];
    endproperty
    a_hdr: assert property (p_hdr) else $error("illegal header");

    property p_multiblock_end_pattern;
        m64 && blk_end && ext_cnt[7:3] == 5'h1F |=> block_out[0:1] == 2'b01 && $past(hdr_bit);
    endproperty
    a_multiblock_end_pattern: assert property (p_multiblock_end_pattern) else $error("multiblock end bit wrong");

    c_lane_alignment_sequence: cover property (in_cgs ##1 in_lane_alignment_sequence);
    c_data: cover property (in_lane_alignment_sequence ##1 in_data);
    c_subst: cover property (in_data && (a_sub || f_sub));
    c_block: cover property (block_valid_out && $past(ext_cnt[7:3]) == 5'h1F);
endmodule // sll_link_tx

// File: bench/sll_rx_model.sv
// Link receiver model: comma lock, SYNC release and alignment character checks
`timescale 1ns/10ps
module sll_rx_model #(
    parameter int F = 2,
    parameter int FK = 18
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Link side
    input wire logic go_in,
    input wire logic [9:0] char_in,
    input wire logic valid_in,
    output logic sync_n_out = 1'b0
);
    // ======================================================================
    // Control character decode, either disparity
    logic neg_rd;
    logic is_k;
    logic [3:0] kind;
    int run, multiframe_boundary_counter, pos, n_comma, n_r, n_a, n_f, n_q, n_bad;
    assign neg_rd = char_in[9:4] == 6'b001111;
    assign is_k = neg_rd || char_in[9:4] == 6'b110000;
    assign kind = neg_rd ? char_in[3:0] : ~char_in[3:0];
    // ======================================================================
    // Lock and position tracking
    always_ff @(posedge clk_in) begin
        multiframe_boundary_counter <= (multiframe_boundary_counter + 1) % FK;
        if (valid_in && is_k && kind == 4'hA) begin
            n_comma <= n_comma + 1;
        end
        if (reset_in || !go_in) begin
            sync_n_out <= 1'b0;
            run <= 0;
            pos <= -1;
        end else if (valid_in && is_k) begin
            run <= kind == 4'hA ? run + 1 : 0;
            // Release only on own boundary after four commas
            if (run >= 4 && multiframe_boundary_counter == 0) sync_n_out <= 1'b1;
            if (pos >= 0) pos <= pos + 1;
            // Kind is the negative-disparity tail: K28.0=4, K28.3=3, K28.4=2, K28.7=8
            if (kind == 4'h4 && pos < 0) pos <= 1;
            if (kind == 4'h4) n_r <= n_r + 1;
            if (kind == 4'h3) n_a <= n_a + 1;
            if (kind == 4'h8) n_f <= n_f + 1;
            if (kind == 4'h2) n_q <= n_q + 1;
            if ((kind == 4'h4 && pos > 0 && pos % FK != 0) || (kind == 4'h3 && pos % FK != FK - 1)
                || (kind == 4'h8 && pos % F != F - 1) || (kind == 4'hA && pos >= 0)) begin
                n_bad <= n_bad + 1;
            end
        end else if (valid_in) begin
            run <= 0;
            if (pos >= 0) pos <= pos + 1;
        end
    end
endmodule // sll_rx_model

// File: bench/sll_link_tx_tb.sv
// Self-checking bench for the serial link layer transmitter
`timescale 1ns/10ps
module sll_link_tx_tb;
    localparam int F = 2;
    localparam int FK = 18;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, sync_n, char_valid, octet_ready, block_valid;
    logic sysref = 1'b0, go = 1'b0, inc = 1'b0, octet_valid = 1'b0;
    logic [7:0] octet = 8'h00;
    logic [9:0] char;
    logic [0:65] block;
    int errors = 0, checks = 0, b0, b1, b2;

    sll_link_tx i_dut (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .sync_n_in(sync_n), .sysref_in(sysref), .octet_in(octet),
        .octet_valid_in(octet_valid), .octet_ready_out(octet_ready), .char_out(char),
        .char_valid_out(char_valid), .block_out(block), .block_valid_out(block_valid));
    sll_rx_model #(.F(F), .FK(FK)) i_rx (.clk_in(clk_in), .reset_in(reset_in), .go_in(go),
        .char_in(char), .valid_in(char_valid), .sync_n_out(sync_n));

    initial begin
        forever #4 clk_in = ~clk_in;
    end
    // Changing octets keep frame ends distinct, so no substitution
    always @(posedge clk_in) begin
        if (inc) octet <= octet + 8'h01;
    end
    // ======================================================================
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("apb ready", 32'h1, {31'h0, pready});
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic wait_state(input logic [1:0] st);
        int n;
        n = 0;
        do begin
            apb(1'b0, 12'h008, 32'h0);
            n++;
        end while (q[1:0] !== st && n < 100);
        chk("link state", {30'h0, st}, {30'h0, q[1:0]});
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ======================================================================
    // Scenarios
    task automatic t_regs;
        logic [31:0] cfg [4] = '{32'h00000701, 32'h0000CC04, 32'h0000FF03, 32'h00000801};
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl reset", 32'h0, q);
        apb(1'b0, 12'h004, 32'h0);
        chk("cfg reset", 32'h00001F01, q);
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h004, cfg[i]);
            apb(1'b0, 12'h008, 32'h0);
            chk("fk range flag", {31'h0, i < 2}, {31'h0, q[3]});
        end
        $display("t_regs done");
    endtask
    task automatic t_cgs;
        b0 = i_rx.n_comma;
        apb(1'b1, 12'h000, 32'h1);
        wait_state(2'h1);
        repeat (40) @(posedge clk_in);
        chk("commas sent", 1, i_rx.n_comma - b0 > 30);
        chk("octet ready in comma phase", 32'h0, {31'h0, octet_ready});
        $display("t_cgs done");
    endtask
    task automatic t_lane_alignment_sequence;
        b0 = i_rx.n_r;
        b1 = i_rx.n_a;
        b2 = i_rx.n_q;
        inc <= 1'b1;
        octet_valid <= 1'b1;
        go <= 1'b1;
        wait_state(2'h3);
        repeat (4 * FK) @(posedge clk_in);
        chk("start markers", 4, i_rx.n_r - b0);
        chk("end markers", 4, i_rx.n_a - b1);
        chk("config marker", 1, i_rx.n_q - b2);
        chk("no frame marks", 0, i_rx.n_f);
        chk("octet ready in data", 32'h1, {31'h0, octet_ready});
        inc <= 1'b0;
        repeat (4 * FK) @(posedge clk_in);
        chk("repeat frame marks", 1, i_rx.n_f > 2 * (FK / F - 1));
        chk("repeat mf marks", 1, i_rx.n_a - b1 > 6);
        chk("marker positions", 0, i_rx.n_bad);
        $display("t_lane_alignment_sequence done");
    endtask
    task automatic t_realign;
        go <= 1'b0;
        wait_state(2'h1);
        apb(1'b1, 12'h000, 32'h5);
        b0 = i_rx.n_r;
        go <= 1'b1;
        wait_state(2'h3);
        repeat (4 * FK) @(posedge clk_in);
        chk("restart markers", 4, i_rx.n_r - b0);
        chk("scrambled marks", 0, i_rx.n_bad);
        $display("t_realign done");
    endtask
    task automatic t_b64;
        logic [31:0] hs [2];
        int n;
        apb(1'b1, 12'h000, 32'h3);
        sysref <= 1'b1;
        repeat (4) @(posedge clk_in);
        sysref <= 1'b0;
        repeat (4) @(posedge clk_in);
        for (int i = 0; i < 64; i++) begin
            n = 0;
            do begin
                @(negedge clk_in);
                n++;
            end while (block_valid !== 1'b1 && n < 20);
            if (i > 0) chk("block spacing", 8, n);
            chk("header legal", 1, block[0] ^ block[1]);
            hs[i / 32][i % 32] = block[1];
        end
        chk("multiblock repeat", hs[0], hs[1]);
        chk("end pattern", 1, {hs[0][27], hs[0][28], hs[0][29], hs[0][30], hs[0][31]});
        chk("ext end flag", 1, hs[0][22]);
        chk("octets scrambled", 1, block[2:65] != 64'h0);
        chk("octet ready in block mode", 32'h1, {31'h0, octet_ready});
        $display("t_b64 done");
    endtask
    // ======================================================================
    // Main sequence and watchdog
    initial begin
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        t_regs;
        t_cgs;
        t_lane_alignment_sequence;
        t_realign;
        t_b64;
        stop_test;
    end
    initial begin
        #200000;
        errors++;
        $display("Error watchdog expected finish seen timeout");
        stop_test;
    end
endmodule // sll_link_tx_tb
